//--- bench/tb_touch_probe_edge_qualifier.sv
`timescale 1ns/10ps
`default_nettype none
module tb_touch_probe_edge_qualifier;
  logic clk, rst_b, regWr, regRd, dirUp, irq, dir;
  logic [1:0] press, probeIn, hitPulse, seen;
  tpq_pkg::tpq_step_type posStep;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata, truePos, pos;
  int mismatches, n_compared, cycles, cnt;
  // short prescaler keeps the whole run to a few thousand cycles
  localparam int TICK = 40;
  touch_probe_edge_qualifier #(.TICK_CYCLES(TICK)) dut (.clk(clk), .rst_b(rst_b), .probeIn(probeIn),
    .posStep(posStep), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irq(irq), .hitPulse(hitPulse), .truePos(truePos), .dirUp(dirUp));
  tpq_probe_sw sw0 (.clk(clk), .press(press[0]), .contact(probeIn[0]));
  tpq_probe_sw sw1 (.clk(clk), .press(press[1]), .contact(probeIn[1]));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task results;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results;
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    // step off the edge so a following call never re-drives the strobe now
    #1;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk("regRdata", exp, regRdata);
  endtask
  task run(input logic up, input int n);
    repeat (n) begin
      posStep <= '{1'b1, up};
      @(posedge clk);
      posStep <= '{1'b0, up};
      pos = up ? pos + 1 : pos - 1;
      cnt = (up == dir) ? 0 : cnt + 1;
      // direction factor left at its reset value of 40
      if (cnt >= 40) begin
        dir = up;
        cnt = 0;
      end
      @(posedge clk);
      #1 chk("dirUp", {31'h0, dir}, {31'h0, dirUp});
    end
  endtask
  function automatic logic [1:0] hitExp(input logic [1:0] sel, input logic rising);
    return (rising ? sel[0] : sel[1]) ? 2'h3 : 2'h0;
  endfunction
  task contact(input logic [1:0] p, input logic [1:0] exp);
    press <= p;
    seen = 2'h0;
    repeat (6 * TICK) begin
      @(posedge clk);
      #1 seen |= hitPulse;
    end
    chk("hitPulse", {30'h0, exp}, {30'h0, seen});
    chk("irq", {31'h0, exp[0]}, {31'h0, irq});
    if (exp[0]) chk("truePos", dir ? pos - 32'h32 : pos + 32'h32, truePos);
    wr(tpq_pkg::ADR_STAT, 32'h00000007);
    @(posedge clk);
    #1 chk("irq", 32'h0, {31'h0, irq});
  endtask
  initial begin
    void'($urandom(31421));
    {rst_b, regWr, regRd, regAddr, regWdata, press, dir, cnt, pos} = '0;
    dir = 1'b1;
    posStep = '{1'b0, 1'b0};
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(tpq_pkg::ADR_CTRL, 32'h00000010);
    rd(tpq_pkg::ADR_DEB, 32'h00000032);
    rd(tpq_pkg::ADR_DIRF, 32'h00000028);
    rd(tpq_pkg::ADR_DELAY, 32'h00000000);
    rd(4'hC, 32'h00000000);
    run(1'b0, 39);
    run(1'b1, 1);
    run(1'b0, 40);
    repeat (6) run(1'($urandom % 2), 1 + $urandom % 60);
    // two ticks: a chattering contact can never look settled for that long
    wr(tpq_pkg::ADR_DEB, 32'h00000002);
    wr(tpq_pkg::ADR_DIA, 32'h00000064);
    wr(tpq_pkg::ADR_MASK, 32'h00000001);
    for (int t = 0; t < 4; t++) begin
      run(1'(t), 40);
      wr(tpq_pkg::ADR_CTRL, {26'h0, 2'b11, 2'(t), 2'(t)});
      contact(2'h3, hitExp(2'(t), 1'b1));
      contact(2'h0, hitExp(2'(t), 1'b0));
    end
    // teach: rise then fall on channel 0, forty counts apart
    wr(tpq_pkg::ADR_STDSZ, 32'h00000100);
    wr(tpq_pkg::ADR_TEACH, 32'h00000001);
    contact(2'h3, 2'h3);
    run(1'b1, 40);
    contact(2'h0, 2'h3);
    rd(tpq_pkg::ADR_DIA, 32'h000000D8);
    rd(tpq_pkg::ADR_TEACH, 32'h00000000);
    wr(tpq_pkg::ADR_DIA, 32'h00000064);
    // hold-off far longer than one contact window, so the release is refused
    wr(tpq_pkg::ADR_DELAY, 32'h00000014);
    contact(2'h3, 2'h3);
    contact(2'h0, 2'h0);
    repeat (20 * TICK) @(posedge clk);
    contact(2'h3, 2'h3);
    rd(tpq_pkg::ADR_LIVE, {29'h0, dir, 2'h3});
    results;
  end
endmodule
bind touch_probe_edge_qualifier tpq_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clk(clk),
  .rst_b(rst_b),
  .posStep(posStep), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
  .hitPulse(hitPulse), .truePos(truePos), .dirUp(dirUp));
`default_nettype wire

//--- bench/tpq_probe_sw.sv
`timescale 1ns/10ps
`default_nettype none
module tpq_probe_sw #(
  parameter int BOUNCE = 40
) (
  input wire logic clk,
  input wire logic press,
  output logic contact = 1'b0
);
  int chatter = 0;
  logic last = 1'b0;
  // a real contact chatters after every change, never settles at once
  always @(posedge clk) begin
    last <= press;
    if (press != last) chatter <= BOUNCE;
    else if (chatter != 0) chatter <= chatter - 1;
    contact <= (chatter != 0) ? ~contact : last;
  end
endmodule
`default_nettype wire

//--- bench/tpq_properties.sv
`timescale 1ns/10ps
`default_nettype none
module tpq_properties #(
  parameter int TICK_CYCLES = tpq_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire tpq_pkg::tpq_step_type posStep,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic irq,
  input wire logic [tpq_pkg::NCH-1:0] hitPulse,
  input wire logic [tpq_pkg::POS_W-1:0] truePos,
  input wire logic dirUp
);
  logic [17:0] sinceRst_ff;
  // saturates so a long run never wraps back under the first tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sinceRst_ff <= 18'h00000;
    else if (!(&sinceRst_ff)) sinceRst_ff <= sinceRst_ff + 18'h00001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_rdIdle; !$past(regRd) |-> regRdata == 32'h00000000; endproperty
  property p_hitGap0; hitPulse[0] |=> !hitPulse[0] [*8]; endproperty
  property p_hitGap1; hitPulse[1] |=> !hitPulse[1] [*8]; endproperty
  property p_firstTick; hitPulse != 2'h0 |-> sinceRst_ff >= TICK_CYCLES - 1; endproperty
  property p_dirStep; $changed(dirUp) |-> $past(posStep.step) || $past(posStep.step, 2); endproperty
  property p_dirSide;
    $changed(dirUp) |-> dirUp == ($past(posStep.step) ? $past(posStep.up) : $past(posStep.up, 2));
  endproperty
  property p_irqCause;
    $changed(irq) |-> $past(regWr) || hitPulse != 2'h0 || $past(hitPulse) != 2'h0;
  endproperty
  property p_posCause; $changed(truePos) |-> hitPulse[0] || $past(hitPulse[0]); endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
  a_hitGap0: assert property (p_hitGap0) else $error("channel 0 hits too close");
  a_hitGap1: assert property (p_hitGap1) else $error("channel 1 hits too close");
  a_firstTick: assert property (p_firstTick) else $error("hit before first tick");
  a_dirStep: assert property (p_dirStep) else $error("direction moved without step");
  a_dirSide: assert property (p_dirSide) else $error("direction against step");
  a_irqCause: assert property (p_irqCause) else $error("irq moved without cause");
  a_posCause: assert property (p_posCause) else $error("position moved without hit");
  c_hit: cover property (hitPulse == 2'h3);
  c_down: cover property ($fell(dirUp));
  c_read: cover property (regRd ##1 regRdata != 32'h00000000);
endmodule
`default_nettype wire

//--- hw/touch_probe_edge_qualifier.sv
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module touch_probe_edge_qualifier #(
  // prescaler length; a full millisecond makes simulation far too slow
  parameter int TICK_CYCLES = tpq_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [tpq_pkg::NCH-1:0] probeIn,
  input wire tpq_pkg::tpq_step_type posStep,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic irq,
  output logic [tpq_pkg::NCH-1:0] hitPulse,
  output logic [tpq_pkg::POS_W-1:0] truePos,
  output logic dirUp
);
  typedef struct packed {
    logic [tpq_pkg::NCH-1:0][1:0] edgeSel;
    logic [tpq_pkg::NCH-1:0] chanEn;
    logic [tpq_pkg::MS_W-1:0] delayMs;
    logic [tpq_pkg::MS_W-1:0] debMs;
    logic [tpq_pkg::DIR_W-1:0] dirFactor;
    logic [tpq_pkg::DIA_W-1:0] tipDia;
    logic [tpq_pkg::DIA_W-1:0] stdSize;
    logic [tpq_pkg::ST_W-1:0] status;
    logic [tpq_pkg::ST_W-1:0] mask;
    logic [tpq_pkg::POS_W-1:0] position;
    logic dirUp;
    logic [tpq_pkg::DIR_W-1:0] revCnt;
    logic [tpq_pkg::NCH-1:0][tpq_pkg::POS_W-1:0] hitPos;
    logic teachArmed;
    logic teachHaveFirst;
    logic [tpq_pkg::POS_W-1:0] teachFirst;
    logic [tpq_pkg::NCH-1:0] hitPulse;
    logic [31:0] rdata;
  } tpq_top_st_type;
  tpq_top_st_type st_ff;
  tpq_top_st_type nxt_st;

  logic msTick;
  logic [tpq_pkg::NCH-1:0] chHit;
  logic [tpq_pkg::NCH-1:0] chLevel;

  tpq_ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .tick(msTick)
  );

  // one qualifier per probe; second one idles unless enabled
  genvar g;
  generate
    for (g = 0; g < tpq_pkg::NCH; g++) begin : g_ch
      tpq_pkg::tpq_chcfg_type cfg;
      always_comb begin
        cfg.edgeSel = st_ff.chanEn[g] ? tpq_pkg::tpq_edge_type'(st_ff.edgeSel[g])
                                      : tpq_pkg::TPQ_OFF;
        cfg.delayMs = st_ff.delayMs;
        cfg.debMs = st_ff.debMs;
      end
      tpq_channel u_ch (
        .clk(clk),
        .rst_b(rst_b),
        .msTick(msTick),
        .probeIn(probeIn[g]),
        .cfg(cfg),
        .hit(chHit[g]),
        .level(chLevel[g])
      );
    end
  endgenerate

  function automatic logic [tpq_pkg::POS_W-1:0] comp(
    input logic [tpq_pkg::POS_W-1:0] pos,
    input logic up,
    input logic [tpq_pkg::DIA_W-1:0] dia
  );
    logic [tpq_pkg::POS_W-1:0] half;
    half = tpq_pkg::POS_W'(dia >> 1);
    // tip leads the centre, so back off by the radius against motion
    comp = up ? pos - half : pos + half;
  endfunction

  always_comb begin
    logic [tpq_pkg::POS_W-1:0] span;
    logic [tpq_pkg::ST_W-1:0] ev;
    ev = '0;
    span = '0;
    nxt_st = st_ff;
    nxt_st.hitPulse = '0;
    nxt_st.rdata = '0;

    if (posStep.step) begin
      nxt_st.position = posStep.up ? st_ff.position + 1'b1 : st_ff.position - 1'b1;
      if (posStep.up == st_ff.dirUp) begin
        nxt_st.revCnt = '0;
      end else if (st_ff.revCnt + 1'b1 >= st_ff.dirFactor) begin
        nxt_st.dirUp = posStep.up;
        nxt_st.revCnt = '0;
      end else begin
        nxt_st.revCnt = st_ff.revCnt + 1'b1;
      end
    end

    for (int i = 0; i < tpq_pkg::NCH; i++) begin
      if (chHit[i]) begin
        nxt_st.hitPos[i] = comp(st_ff.position, st_ff.dirUp, st_ff.tipDia);
        nxt_st.hitPulse[i] = 1'b1;
        ev[tpq_pkg::ST_HIT0 + i] = 1'b1;
      end
    end

    // teach: two qualified channel 0 contacts on opposite faces of the standard
    if (st_ff.teachArmed && chHit[0]) begin
      if (!st_ff.teachHaveFirst) begin
        nxt_st.teachFirst = st_ff.position;
        nxt_st.teachHaveFirst = 1'b1;
      end else begin
        span = (st_ff.position > st_ff.teachFirst) ? st_ff.position - st_ff.teachFirst
                                                   : st_ff.teachFirst - st_ff.position;
        // gap between centres is standard minus one diameter
        nxt_st.tipDia = tpq_pkg::DIA_W'(tpq_pkg::POS_W'(st_ff.stdSize) - span);
        nxt_st.teachArmed = 1'b0;
        nxt_st.teachHaveFirst = 1'b0;
        ev[tpq_pkg::ST_TEACH] = 1'b1;
      end
    end

    if (regWr) begin
      unique case (regAddr)
        tpq_pkg::ADR_CTRL: begin
          nxt_st.edgeSel[0] = regWdata[1:0];
          nxt_st.edgeSel[1] = regWdata[3:2];
          nxt_st.chanEn = regWdata[5:4];
        end
        tpq_pkg::ADR_DELAY: nxt_st.delayMs = regWdata[tpq_pkg::MS_W-1:0];
        tpq_pkg::ADR_DEB: nxt_st.debMs = regWdata[tpq_pkg::MS_W-1:0];
        tpq_pkg::ADR_DIRF: nxt_st.dirFactor = regWdata[tpq_pkg::DIR_W-1:0];
        tpq_pkg::ADR_DIA: nxt_st.tipDia = regWdata[tpq_pkg::DIA_W-1:0];
        tpq_pkg::ADR_STAT: nxt_st.status = st_ff.status & ~regWdata[tpq_pkg::ST_W-1:0];
        tpq_pkg::ADR_MASK: nxt_st.mask = regWdata[tpq_pkg::ST_W-1:0];
        tpq_pkg::ADR_TEACH: begin
          nxt_st.teachArmed = regWdata[0];
          nxt_st.teachHaveFirst = 1'b0;
        end
        tpq_pkg::ADR_STDSZ: nxt_st.stdSize = regWdata[tpq_pkg::DIA_W-1:0];
        default: ;
      endcase
    end
    // set wins over a same-cycle clear
    nxt_st.status = nxt_st.status | ev;

    if (regRd) begin
      unique case (regAddr)
        tpq_pkg::ADR_CTRL: nxt_st.rdata = 32'(
          {st_ff.chanEn, st_ff.edgeSel[1], st_ff.edgeSel[0]});
        tpq_pkg::ADR_DELAY: nxt_st.rdata = 32'(st_ff.delayMs);
        tpq_pkg::ADR_DEB: nxt_st.rdata = 32'(st_ff.debMs);
        tpq_pkg::ADR_DIRF: nxt_st.rdata = 32'(st_ff.dirFactor);
        tpq_pkg::ADR_DIA: nxt_st.rdata = 32'(st_ff.tipDia);
        tpq_pkg::ADR_STAT: nxt_st.rdata = 32'(st_ff.status);
        tpq_pkg::ADR_MASK: nxt_st.rdata = 32'(st_ff.mask);
        tpq_pkg::ADR_HIT0: nxt_st.rdata = st_ff.hitPos[0];
        tpq_pkg::ADR_HIT1: nxt_st.rdata = st_ff.hitPos[1];
        tpq_pkg::ADR_TEACH: nxt_st.rdata = 32'({st_ff.teachHaveFirst, st_ff.teachArmed});
        tpq_pkg::ADR_STDSZ: nxt_st.rdata = 32'(st_ff.stdSize);
        tpq_pkg::ADR_LIVE: nxt_st.rdata = 32'({st_ff.dirUp, chLevel});
        default: nxt_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
      st_ff.chanEn <= tpq_pkg::CHEN_RST;
      st_ff.delayMs <= tpq_pkg::DELAY_RST;
      st_ff.debMs <= tpq_pkg::DEB_RST;
      st_ff.dirFactor <= tpq_pkg::DIRF_RST;
      st_ff.tipDia <= tpq_pkg::DIA_RST;
      st_ff.dirUp <= tpq_pkg::DIRUP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign regRdata = st_ff.rdata;
  assign irq = |(st_ff.status & st_ff.mask);
  assign hitPulse = st_ff.hitPulse;
  assign truePos = st_ff.hitPos[0];
  assign dirUp = st_ff.dirUp;
endmodule
`default_nettype wire

//--- hw/tpq_channel.sv
`timescale 1ns/10ps
`default_nettype none
module tpq_channel (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic msTick,
  input wire logic probeIn,
  input wire tpq_pkg::tpq_chcfg_type cfg,
  output logic hit,
  output logic level
);
  typedef struct packed {
    logic stable;
    logic [tpq_pkg::MS_W-1:0] settle;
    logic [tpq_pkg::MS_W-1:0] hold;
    logic hit;
  } tpq_ch_st_type;
  tpq_ch_st_type st_ff;
  tpq_ch_st_type nxt_st;

  always_comb begin
    logic rise;
    logic fall;
    logic accept;
    rise = 1'b0;
    fall = 1'b0;
    accept = 1'b0;
    nxt_st = st_ff;
    nxt_st.hit = 1'b0;
    if (msTick && st_ff.hold != '0) begin
      nxt_st.hold = st_ff.hold - 1'b1;
    end
    // settle counter restarts whenever input matches the accepted level
    if (probeIn == st_ff.stable) begin
      nxt_st.settle = '0;
    end else if (msTick) begin
      if (st_ff.settle + 1'b1 >= cfg.debMs) begin
        nxt_st.stable = probeIn;
        nxt_st.settle = '0;
        rise = probeIn;
        fall = !probeIn;
      end else begin
        nxt_st.settle = st_ff.settle + 1'b1;
      end
    end
    unique case (cfg.edgeSel)
      tpq_pkg::TPQ_OFF: accept = 1'b0;
      tpq_pkg::TPQ_RISE: accept = rise;
      tpq_pkg::TPQ_FALL: accept = fall;
      tpq_pkg::TPQ_BOTH: accept = rise | fall;
    endcase
    if (accept && st_ff.hold == '0) begin
      nxt_st.hit = 1'b1;
      nxt_st.hold = cfg.delayMs;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hit = st_ff.hit;
  assign level = st_ff.stable;
endmodule
`default_nettype wire

//--- hw/tpq_ms_tick.sv
`timescale 1ns/10ps
`default_nettype none
module tpq_ms_tick #(
  // shortened only in simulation; real use keeps one millisecond
  parameter int TICK_CYCLES = tpq_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic tick
);
  typedef struct packed {
    logic [tpq_pkg::PRE_W-1:0] cnt;
    logic tick;
  } tpq_tick_st_type;
  tpq_tick_st_type st_ff;
  tpq_tick_st_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == tpq_pkg::PRE_W'(TICK_CYCLES - 1)) begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;
endmodule
`default_nettype wire

//--- hw/tpq_pkg.sv
package tpq_pkg;
  localparam int CLK_HZ = 125000000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int PRE_W = 17;
  localparam int NCH = 2;
  localparam int MS_W = 16;
  localparam int POS_W = 32;
  localparam int DIA_W = 24;
  localparam int DIR_W = 16;

  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_DELAY = 4'h1;
  localparam logic [3:0] ADR_DEB = 4'h2;
  localparam logic [3:0] ADR_DIRF = 4'h3;
  localparam logic [3:0] ADR_DIA = 4'h4;
  localparam logic [3:0] ADR_STAT = 4'h5;
  localparam logic [3:0] ADR_MASK = 4'h6;
  localparam logic [3:0] ADR_HIT0 = 4'h7;
  localparam logic [3:0] ADR_HIT1 = 4'h8;
  localparam logic [3:0] ADR_TEACH = 4'h9;
  localparam logic [3:0] ADR_STDSZ = 4'hA;
  localparam logic [3:0] ADR_LIVE = 4'hB;

  localparam logic [MS_W-1:0] DELAY_RST = 16'h0000;
  localparam logic [MS_W-1:0] DEB_RST = 16'h0032;
  localparam logic [DIR_W-1:0] DIRF_RST = 16'h0028;
  localparam logic [DIA_W-1:0] DIA_RST = 24'h000000;
  localparam logic [NCH-1:0] CHEN_RST = 2'h1;
  localparam logic DIRUP_RST = 1'b1;

  // status bit positions: hit per channel, then teach done
  localparam int ST_HIT0 = 0;
  localparam int ST_TEACH = 2;
  localparam int ST_W = 3;

  typedef enum logic [1:0] {
    TPQ_OFF = 2'b00,
    TPQ_RISE = 2'b01,
    TPQ_FALL = 2'b10,
    TPQ_BOTH = 2'b11
  } tpq_edge_type;

  typedef struct packed {
    tpq_edge_type edgeSel;
    logic [MS_W-1:0] delayMs;
    logic [MS_W-1:0] debMs;
  } tpq_chcfg_type;

  typedef struct packed {
    logic step;
    logic up;
  } tpq_step_type;
endpackage
